// ---- include/gtf_pkg.sv ----
// Constants and types for the gain trim and FIR configuration register bank.
// Assumes a single 25 MHz clock domain and an 8-bit register port.
package gtf_pkg;

   // ***********************************************
   // Register port geometry
   // ***********************************************
   localparam int ADDR_W = 12;
   localparam int DATA_W = 8;
   localparam int GAIN_W = 5;
   localparam int SCW_W  = 3;
   localparam int EXP_W  = 6;

   // ***********************************************
   // Register offsets
   // ***********************************************
   localparam logic [ADDR_W-1:0] OFF_GAIN_B0 = 12'h356;
   localparam logic [ADDR_W-1:0] OFF_GAIN_B1 = 12'h357;
   localparam logic [ADDR_W-1:0] OFF_FIR_CFG = 12'h400;
   localparam logic [ADDR_W-1:0] OFF_STATUS  = 12'h401;

   // ***********************************************
   // Reset values and field layout
   // ***********************************************
   localparam logic [DATA_W-1:0] RST_GAIN    = 8'h00;
   localparam logic [DATA_W-1:0] RST_FIR_CFG = 8'h00;
   localparam logic [DATA_W-1:0] RD_ZERO     = 8'h00;
   localparam int GAIN_MSB  = 4;
   localparam int SHARE_BIT = 6;
   localparam int MERGE_BIT = 5;
   localparam int SCW_MSB   = 4;
   localparam int SCW_LSB   = 2;
   localparam int MODE_MSB  = 1;
   localparam int MODE_LSB  = 0;

   // Filter mode codes
   localparam logic [1:0] FIR_MODE_OFF = 2'h0;
   localparam logic [1:0] FIR_MODE_ON  = 2'h2;

   // Side coefficient weight limits and exponent offset
   localparam logic [SCW_W-1:0] SCW_MAX      = 3'h6;
   localparam logic [EXP_W-1:0] LSB_EXP_BASE = 6'h10;

   // Status bit positions
   localparam int ST_FUSE_DONE  = 0;
   localparam int ST_FIR_ON     = 1;
   localparam int ST_MODE_RSVD  = 2;
   localparam int ST_MERGE_MISS = 3;
   localparam int ST_SCW_RANGE  = 4;

   // Fuse loader states, one-hot
   typedef enum logic [2:0] {
      GTF_LD_WAIT = 3'b001,
      GTF_LD_LOAD = 3'b010,
      GTF_LD_DONE = 3'b100
   } gtf_load_t;

endpackage : gtf_pkg

// ---- rtl/gtf_fuse_load.sv ----
// Fuse default loader: captures factory gain trims once after reset.
// Assumes the fuse controller sits on sys_clk and holds ready high once valid.
`timescale 1ns/1ps
`default_nettype none

module gtf_fuse_load
   import gtf_pkg::*;
(
   // Clock and reset
   input  wire logic              sys_clk,
   input  wire logic              rstn,
   // Fuse storage side
   input  wire logic              fuse_ready,
   input  wire logic [GAIN_W-1:0] fuse_gain_b0,
   input  wire logic [GAIN_W-1:0] fuse_gain_b1,
   // Register bank side
   output logic                   load_stb,
   output logic [GAIN_W-1:0]      load_b0,
   output logic [GAIN_W-1:0]      load_b1,
   output logic                   load_done
);

   typedef struct packed {
      gtf_load_t         state;
      logic              stb;
      logic [GAIN_W-1:0] b0;
      logic [GAIN_W-1:0] b1;
   } gtf_ld_st_t;

   gtf_ld_st_t st_r;
   gtf_ld_st_t st_nxt;

   // ***********************************************
   // Next state: fuse values are taken by a clocked step, never at reset
   // ***********************************************
   always_comb begin
      st_nxt     = st_r;
      st_nxt.stb = 1'b0;
      case (st_r.state)
         GTF_LD_WAIT: begin
            if (fuse_ready) begin
               st_nxt.b0    = fuse_gain_b0;
               st_nxt.b1    = fuse_gain_b1;
               st_nxt.stb   = 1'b1;
               st_nxt.state = GTF_LD_LOAD;
            end
         end
         GTF_LD_LOAD: begin
            st_nxt.state = GTF_LD_DONE;
         end
         GTF_LD_DONE: begin
            st_nxt.state = GTF_LD_DONE;
         end
         default: begin
            st_nxt.state = GTF_LD_WAIT;
         end
      endcase
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         st_r <= '{state: GTF_LD_WAIT, stb: 1'b0, b0: '0, b1: '0};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign load_stb  = st_r.stb;
   assign load_b0   = st_r.b0;
   assign load_b1   = st_r.b1;
   assign load_done = (st_r.state == GTF_LD_DONE);

endmodule : gtf_fuse_load

`default_nettype wire

// ---- rtl/gtf_regs.sv ----
// Gain trim and programmable FIR configuration register bank.
// Assumes a register master on sys_clk with one-cycle strobes and a fuse
// controller on the same clock; the filter datapath reads the decoded outputs.
`timescale 1ns/1ps
`default_nettype none

// Contract
// - B bank 0 single-mode trim at 0x356
// - B bank 1 single-mode trim at 0x357
// - Trim defaults come from fuse storage
// - Filter config at 0x400, resets 0x00
// - Share bit makes B use A coefficients
// - Share clear gives B own coefficients
// - Merge bit joins filters into one stream
// - Weight applies to all but centre coefficient
// - Larger weight widens range, coarser precision
// - Side LSB weight is two^(weight-16)
// - Mode 0 off, 2 on, 1/3 reserved
module gtf_regs
   import gtf_pkg::*;
(
   // Clock and reset
   input  wire logic              sys_clk,
   input  wire logic              rstn,
   // Register port
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic [DATA_W-1:0] wdata,
   input  wire logic              wr_en,
   input  wire logic              rd_en,
   output logic [DATA_W-1:0]      rdata,
   // Fuse storage
   input  wire logic              fuse_ready,
   input  wire logic [GAIN_W-1:0] fuse_gain_b0,
   input  wire logic [GAIN_W-1:0] fuse_gain_b1,
   // Converter mode from the channel configuration
   input  wire logic              single_mode,
   // Gain trims to converter B
   output logic [GAIN_W-1:0]      gain_trim_b0,
   output logic [GAIN_W-1:0]      gain_trim_b1,
   // Filter controls
   output logic                   fir_enable,
   output logic                   coef_sel_b_from_a,
   output logic                   filter_merge,
   output logic [SCW_W-1:0]       side_coef_shift,
   output logic signed [EXP_W-1:0] side_lsb_exp,
   output logic                   centre_coef_unscaled
);

   // ***********************************************
   // State
   // ***********************************************
   typedef struct packed {
      logic [DATA_W-1:0] gain_b0;
      logic [DATA_W-1:0] gain_b1;
      logic [DATA_W-1:0] fir_cfg;
      logic [DATA_W-1:0] rdata;
      logic              fir_en;
      logic              sel_a;
      logic              merge;
      logic [SCW_W-1:0]  shift;
      logic [EXP_W-1:0]  lsb_exp;
      logic              mode_rsvd;
      logic              merge_miss;
      logic              scw_bad;
   } gtf_st_t;

   gtf_st_t st_r;
   gtf_st_t st_nxt;

   logic              load_stb;
   logic [GAIN_W-1:0] load_b0;
   logic [GAIN_W-1:0] load_b1;
   logic              load_done;

   // Field views of the stored configuration
   logic              cfg_share;
   logic              cfg_merge;
   logic [SCW_W-1:0]  cfg_scw;
   logic [1:0]        cfg_mode;
   logic [DATA_W-1:0] status_val;

   assign cfg_share = st_r.fir_cfg[SHARE_BIT];
   assign cfg_merge = st_r.fir_cfg[MERGE_BIT];
   assign cfg_scw   = st_r.fir_cfg[SCW_MSB:SCW_LSB];
   assign cfg_mode  = st_r.fir_cfg[MODE_MSB:MODE_LSB];

   // ***********************************************
   // Fuse default loader
   // ***********************************************
   gtf_fuse_load u_fuse_load (
      .sys_clk      (sys_clk),
      .rstn         (rstn),
      .fuse_ready   (fuse_ready),
      .fuse_gain_b0 (fuse_gain_b0),
      .fuse_gain_b1 (fuse_gain_b1),
      .load_stb     (load_stb),
      .load_b0      (load_b0),
      .load_b1      (load_b1),
      .load_done    (load_done)
   );

   // Status view: loader progress and host programming slips
   always_comb begin
      status_val                = RD_ZERO;
      status_val[ST_FUSE_DONE]  = load_done;
      status_val[ST_FIR_ON]     = st_r.fir_en;
      status_val[ST_MODE_RSVD]  = st_r.mode_rsvd;
      status_val[ST_MERGE_MISS] = st_r.merge_miss;
      status_val[ST_SCW_RANGE]  = st_r.scw_bad;
   end

   // ***********************************************
   // Next state
   // ***********************************************
   always_comb begin
      st_nxt       = st_r;
      st_nxt.rdata = RD_ZERO;

      // Software writes; reserved bits are stored as written
      if (wr_en) begin
         if (addr == OFF_GAIN_B0) begin
            st_nxt.gain_b0 = wdata;
         end else if (addr == OFF_GAIN_B1) begin
            st_nxt.gain_b1 = wdata;
         end else if (addr == OFF_FIR_CFG) begin
            st_nxt.fir_cfg = wdata;
         end
      end

      // Fuse defaults land once and win over a write in the same cycle
      if (load_stb) begin
         st_nxt.gain_b0 = {{(DATA_W-GAIN_W){1'b0}}, load_b0};
         st_nxt.gain_b1 = {{(DATA_W-GAIN_W){1'b0}}, load_b1};
      end

      // Read data valid only in the cycle after the strobe
      if (rd_en) begin
         if (addr == OFF_GAIN_B0) begin
            st_nxt.rdata = st_r.gain_b0;
         end else if (addr == OFF_GAIN_B1) begin
            st_nxt.rdata = st_r.gain_b1;
         end else if (addr == OFF_FIR_CFG) begin
            st_nxt.rdata = st_r.fir_cfg;
         end else if (addr == OFF_STATUS) begin
            st_nxt.rdata = status_val;
         end
      end

      // Decoded filter controls, registered so outputs come from flops
      st_nxt.fir_en    = (cfg_mode == FIR_MODE_ON);
      st_nxt.mode_rsvd = (cfg_mode != FIR_MODE_ON) && (cfg_mode != FIR_MODE_OFF);
      st_nxt.sel_a     = cfg_share;
      st_nxt.merge     = cfg_merge;
      // Weight is a left shift of the side taps: more range, less precision
      st_nxt.shift     = cfg_scw;
      st_nxt.lsb_exp   = EXP_W'(cfg_scw) - LSB_EXP_BASE;
      // Host slips are flagged, never corrected, so the filter sees what was written
      st_nxt.merge_miss = single_mode && !cfg_merge;
      st_nxt.scw_bad    = (cfg_scw > SCW_MAX);
   end

   // ***********************************************
   // Registers
   // ***********************************************
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         st_r.gain_b0    <= RST_GAIN;
         st_r.gain_b1    <= RST_GAIN;
         st_r.fir_cfg    <= RST_FIR_CFG;
         st_r.rdata      <= RD_ZERO;
         st_r.fir_en     <= 1'b0;
         st_r.sel_a      <= 1'b0;
         st_r.merge      <= 1'b0;
         st_r.shift      <= '0;
         // Zero weight decodes to minus sixteen, so hold that value through reset as well
         st_r.lsb_exp    <= -LSB_EXP_BASE;
         st_r.mode_rsvd  <= 1'b0;
         st_r.merge_miss <= 1'b0;
         st_r.scw_bad    <= 1'b0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ***********************************************
   // Outputs
   // ***********************************************
   assign rdata                = st_r.rdata;
   assign gain_trim_b0         = st_r.gain_b0[GAIN_MSB:0];
   assign gain_trim_b1         = st_r.gain_b1[GAIN_MSB:0];
   assign fir_enable           = st_r.fir_en;
   assign coef_sel_b_from_a    = st_r.sel_a;
   assign filter_merge         = st_r.merge;
   assign side_coef_shift      = st_r.shift;
   assign side_lsb_exp         = signed'(st_r.lsb_exp);
   // Centre tap keeps its native weight only while the filter mode is on
   assign centre_coef_unscaled = st_r.fir_en;

   // ***********************************************
   // Checks
   // ***********************************************
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rstn);

   sequence s_cfg_write;
      wr_en && (addr == OFF_FIR_CFG);
   endsequence

   sequence s_cfg_read;
      rd_en && !wr_en && (addr == OFF_FIR_CFG);
   endsequence

   sequence s_status_read;
      rd_en && !wr_en && (addr == OFF_STATUS);
   endsequence

   sequence s_fuse_strobe;
      load_stb && !load_done;
   endsequence

   sequence s_fuse_settled;
      load_done && !load_stb;
   endsequence

   a_gain_b0_write: assert property (wr_en && !load_stb && addr == OFF_GAIN_B0 ##1 1'b1 |->
      gain_trim_b0 == $past(wdata[GAIN_MSB:0]))
      else $error("bank 0 trim did not take the write");

   a_gain_b1_write: assert property (wr_en && !load_stb && addr == OFF_GAIN_B1 |=>
      gain_trim_b1 == $past(wdata[GAIN_MSB:0]))
      else $error("bank 1 trim did not take the write");

   a_fuse_default_load: assert property (load_stb |=>
      (gain_trim_b0 == $past(load_b0)) && (gain_trim_b1 == $past(load_b1)))
      else $error("fuse defaults not loaded");

   a_cfg_readback: assert property (s_cfg_write ##1 s_cfg_read |=> rdata == $past(wdata, 2))
      else $error("filter config read back differs");

   a_cfg_reset_val: assert property (@(posedge sys_clk) disable iff (1'b0)
      $rose(rstn) |-> (st_r.fir_cfg == RST_FIR_CFG) && !fir_enable)
      else $error("filter config not at reset value");

   a_share_select: assert property (s_cfg_write ##1 !wr_en |=>
      coef_sel_b_from_a == $past(wdata[SHARE_BIT], 2))
      else $error("channel B coefficient select wrong");

   a_own_coefs: assert property (!cfg_share |=> !coef_sel_b_from_a)
      else $error("channel B not on its own coefficients");

   a_merge_follow: assert property (cfg_merge |=> filter_merge)
      else $error("merge control not applied");

   a_lsb_exp: assert property (1'b1 |=>
      side_lsb_exp == signed'(EXP_W'($past(cfg_scw)) - LSB_EXP_BASE))
      else $error("side LSB exponent wrong");

   a_shift_follow: assert property (1'b1 |=> side_coef_shift == $past(cfg_scw))
      else $error("side coefficient shift wrong");

   a_mode_decode: assert property (1'b1 |=> fir_enable == ($past(cfg_mode) == FIR_MODE_ON))
      else $error("filter enable decode wrong");

   a_rdata_idle: assert property (!rd_en |=> rdata == RD_ZERO)
      else $error("read data stood without a read");

   // ***********************************************
   // Checks on the read path and trim storage
   // ***********************************************
   // Read data mirror the trim outputs one cycle on
   a_b0_readback: assert property (rd_en && !wr_en && addr == OFF_GAIN_B0 |=>
      rdata[GAIN_MSB:0] == $past(gain_trim_b0))
      else $error("bank 0 trim read back differs");

   a_b1_readback: assert property (rd_en && !wr_en && addr == OFF_GAIN_B1 |=>
      rdata[GAIN_MSB:0] == $past(gain_trim_b1))
      else $error("bank 1 trim read back differs");

   // Reserved bits are kept as written, so the whole byte reads back
   a_b0_reserved_kept: assert property (wr_en && !load_stb && addr == OFF_GAIN_B0 |=>
      st_r.gain_b0 == $past(wdata))
      else $error("bank 0 byte not stored whole");

   a_b1_reserved_kept: assert property (wr_en && !load_stb && addr == OFF_GAIN_B1 |=>
      st_r.gain_b1 == $past(wdata))
      else $error("bank 1 byte not stored whole");

   // Trims only move on a write or the one-time fuse load
   a_trim_hold: assert property (!wr_en && !load_stb |=>
      $stable(gain_trim_b0) && $stable(gain_trim_b1))
      else $error("trim changed with no write");

   a_unmapped_read: assert property (rd_en && (addr != OFF_GAIN_B0) && (addr != OFF_GAIN_B1) &&
      (addr != OFF_FIR_CFG) && (addr != OFF_STATUS) |=> rdata == RD_ZERO)
      else $error("unmapped read returned data");

   a_status_read: assert property (s_status_read |=>
      (rdata[ST_FUSE_DONE] == $past(load_done)) && (rdata[ST_FIR_ON] == $past(fir_enable)))
      else $error("status read back differs");

   a_fuse_steps: assert property (s_fuse_strobe |=> s_fuse_settled)
      else $error("fuse load did not settle after its strobe");

   a_load_once: assert property (load_done |-> !load_stb)
      else $error("fuse defaults loaded twice");

   // ***********************************************
   // Checks on the stored configuration and its decode
   // ***********************************************
   a_cfg_write_lands: assert property (s_cfg_write |=> st_r.fir_cfg == $past(wdata))
      else $error("filter config write lost");

   a_cfg_hold: assert property (!(wr_en && addr == OFF_FIR_CFG) |=> $stable(st_r.fir_cfg))
      else $error("filter config changed with no write");

   a_share_set: assert property (cfg_share |=> coef_sel_b_from_a)
      else $error("channel B not on shared coefficients");

   a_merge_clear: assert property (!cfg_merge |=> !filter_merge)
      else $error("filters merged without the merge bit");

   a_centre_native: assert property (1'b1 |=>
      centre_coef_unscaled == ($past(cfg_mode) == FIR_MODE_ON))
      else $error("centre tap scaling wrong");

   // Flags lag the stored byte by one cycle; the release edge is skipped as inputs may already stand
   a_mode_rsvd_flag: assert property ($past(rstn) |->
      st_r.mode_rsvd == (($past(cfg_mode) != FIR_MODE_ON) && ($past(cfg_mode) != FIR_MODE_OFF)))
      else $error("reserved mode flag wrong");

   a_merge_miss_flag: assert property ($past(rstn) |->
      st_r.merge_miss == ($past(single_mode) && !$past(cfg_merge)))
      else $error("merge missing flag wrong");

   a_weight_range_flag: assert property ($past(rstn) |->
      st_r.scw_bad == ($past(cfg_scw) > SCW_MAX))
      else $error("weight range flag wrong");

endmodule : gtf_regs

`default_nettype wire

// ---- verif/gtf_regs_tb_top.sv ----
// Self-checking bench for the gain trim and FIR configuration register bank.
// Assumes the bench is the only register master and also plays fuse controller.
`timescale 1ns/1ps
`default_nettype none

module gtf_regs_tb_top import gtf_pkg::*;;

   // ***********************************************
   // Stimulus and observation signals
   // ***********************************************
   logic              sys_clk = 1'b0;
   logic              rstn = 1'b0;
   logic [ADDR_W-1:0] addr = 12'h000;
   logic [DATA_W-1:0] wdata = 8'h00;
   logic              wr_en = 1'b0;
   logic              rd_en = 1'b0;
   logic [DATA_W-1:0] rdata;
   logic              fuse_ready = 1'b0;
   logic [GAIN_W-1:0] fuse_gain_b0 = 5'h15;
   logic [GAIN_W-1:0] fuse_gain_b1 = 5'h0A;
   logic              single_mode = 1'b0;
   logic [GAIN_W-1:0] gain_trim_b0;
   logic [GAIN_W-1:0] gain_trim_b1;
   logic              fir_enable;
   logic              coef_sel_b_from_a;
   logic              filter_merge;
   logic [SCW_W-1:0]  side_coef_shift;
   logic signed [EXP_W-1:0] side_lsb_exp;
   logic              centre_coef_unscaled;
   int                fails = 0;
   int                n_compared = 0;
   int                cycles = 0;
   logic [7:0]        cfg_list [11] = '{8'h00, 8'h01, 8'h03, 8'h02, 8'h46, 8'h2A, 8'h6E, 8'h12, 8'h56, 8'h3A, 8'h66};

   // 25 MHz clock
   always #20 sys_clk = ~sys_clk;

   gtf_regs gtf_regs_inst (
      .sys_clk              (sys_clk),
      .rstn                 (rstn),
      .addr                 (addr),
      .wdata                (wdata),
      .wr_en                (wr_en),
      .rd_en                (rd_en),
      .rdata                (rdata),
      .fuse_ready           (fuse_ready),
      .fuse_gain_b0         (fuse_gain_b0),
      .fuse_gain_b1         (fuse_gain_b1),
      .single_mode          (single_mode),
      .gain_trim_b0         (gain_trim_b0),
      .gain_trim_b1         (gain_trim_b1),
      .fir_enable           (fir_enable),
      .coef_sel_b_from_a    (coef_sel_b_from_a),
      .filter_merge         (filter_merge),
      .side_coef_shift      (side_coef_shift),
      .side_lsb_exp         (side_lsb_exp),
      .centre_coef_unscaled (centre_coef_unscaled)
   );

   // ***********************************************
   // Verdict, compare and bus tasks
   // ***********************************************
   task automatic report_and_stop();
      $display("compared %0d, mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : report_and_stop

   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk

   // One-cycle write strobe, released at the next edge
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge sys_clk);
      addr  <= a;
      wdata <= d;
      wr_en <= 1'b1;
      @(posedge sys_clk);
      wr_en <= 1'b0;
   endtask : wr

   // Read data stand only in the cycle after the strobe, so sample there
   task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e, input string what);
      @(posedge sys_clk);
      addr  <= a;
      rd_en <= 1'b1;
      @(posedge sys_clk);
      rd_en <= 1'b0;
      #1 chk(rdata, e, what);
   endtask : rd

   // Write then read the same place with no idle cycle between the strobes
   task automatic wr_rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input string what);
      @(posedge sys_clk);
      addr  <= a;
      wdata <= d;
      wr_en <= 1'b1;
      @(posedge sys_clk);
      wr_en <= 1'b0;
      rd_en <= 1'b1;
      @(posedge sys_clk);
      rd_en <= 1'b0;
      #1 chk(rdata, d, what);
   endtask : wr_rd

   task automatic settle();
      repeat (2) @(posedge sys_clk);
      #1;
   endtask : settle

   // Decoded filter controls against fields worked out from the written byte
   task automatic chk_cfg(input logic [7:0] c);
      logic [5:0] e;
      e = {3'h0, c[4:2]} - 6'h10;
      chk({7'h0, fir_enable}, {7'h0, c[1:0] == 2'h2}, "enable");
      chk({7'h0, centre_coef_unscaled}, {7'h0, c[1:0] == 2'h2}, "centre");
      chk({7'h0, coef_sel_b_from_a}, {7'h0, c[6]}, "share");
      chk({7'h0, filter_merge}, {7'h0, c[5]}, "merge");
      chk({5'h0, side_coef_shift}, {5'h0, c[4:2]}, "weight");
      chk({2'h0, side_lsb_exp}, {2'h0, e}, "lsb exponent");
   endtask : chk_cfg

   // Cut a hang short; the whole run needs well under a thousand cycles
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         fails++;
         report_and_stop();
      end
   end

   // ***********************************************
   // Main sequence
   // ***********************************************
   initial begin
      repeat (20) @(posedge sys_clk);
      rstn <= 1'b1;
      settle();
      chk({3'h0, gain_trim_b0}, 8'h00, "trim b0 before fuse");
      rd(OFF_GAIN_B0, 8'h00, "trim b0 before fuse");
      rd(OFF_FIR_CFG, 8'h00, "cfg reset");
      rd(OFF_STATUS, 8'h00, "status before fuse");
      // Fuse defaults arrive some time after reset
      @(posedge sys_clk);
      fuse_ready <= 1'b1;
      repeat (4) @(posedge sys_clk);
      #1 chk({3'h0, gain_trim_b0}, 8'h15, "fuse b0");
      chk({3'h0, gain_trim_b1}, 8'h0A, "fuse b1");
      rd(OFF_GAIN_B0, 8'h15, "fuse b0 read");
      rd(OFF_GAIN_B1, 8'h0A, "fuse b1 read");
      // Software overrides the trims one bank at a time
      wr(OFF_GAIN_B0, 8'h1F);
      settle();
      chk({3'h0, gain_trim_b0}, 8'h1F, "trim b0");
      chk({3'h0, gain_trim_b1}, 8'h0A, "trim b1 untouched");
      rd(OFF_GAIN_B0, 8'h1F, "trim b0 read");
      // Read straight after a write, no idle cycle between strobes
      wr_rd(OFF_GAIN_B1, 8'h03, "trim b1 back to back");
      @(posedge sys_clk);
      #1 chk(rdata, 8'h00, "rdata after its cycle");
      chk({3'h0, gain_trim_b1}, 8'h03, "trim b1");
      // Neighbouring unmapped places neither store nor alias
      wr(12'h355, 8'h11);
      rd(12'h355, 8'h00, "unmapped below");
      rd(12'h358, 8'h00, "unmapped above");
      chk({3'h0, gain_trim_b0}, 8'h1F, "trim b0 after stray write");
      // Every mode code, weights 0 to 6, share and merge combinations
      foreach (cfg_list[i]) begin
         wr(OFF_FIR_CFG, cfg_list[i]);
         rd(OFF_FIR_CFG, cfg_list[i], "cfg read back");
         chk_cfg(cfg_list[i]);
      end
      // Single channel operation with the merged filter, status is read only
      @(posedge sys_clk);
      single_mode <= 1'b1;
      wr_rd(OFF_FIR_CFG, 8'h22, "cfg back to back");
      wr(OFF_STATUS, 8'hFF);
      rd(OFF_STATUS, 8'h03, "status");
      settle();
      chk_cfg(8'h22);
      // Weight 7, a reserved mode and merge clear in single mode are only flagged
      wr(OFF_FIR_CFG, 8'h1D);
      rd(OFF_STATUS, 8'h1D, "status slips");
      chk_cfg(8'h1D);
      // A second reset clears the filter setup and reloads the fuse trims
      @(posedge sys_clk);
      rstn <= 1'b0;
      repeat (3) @(posedge sys_clk);
      rstn <= 1'b1;
      repeat (5) @(posedge sys_clk);
      rd(OFF_FIR_CFG, 8'h00, "cfg after reset");
      chk_cfg(8'h00);
      rd(OFF_GAIN_B1, 8'h0A, "fuse b1 reload");
      chk({3'h0, gain_trim_b0}, 8'h15, "fuse b0 reload");
      report_and_stop();
   end

endmodule : gtf_regs_tb_top

`default_nettype wire
